// ==== rtl/sscl_loader.sv ====
// serial setup chain loader: shifts setup bits in, then passes the chain on
// assumes serial clock, serial data and enable pins are asynchronous to clk;
// serial clock must stay well below clk/4 (bench: 800 ns period)
`timescale 1ns/100ps
module sscl_loader
    import sscl_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  serialModeSel,
    input  wire logic                  serialClk,
    input  wire logic                  serialIn,
    input  wire logic                  chain_enable_in_n,
    output logic                       chain_enable_out_n,
    output logic                       serialOut,
    output logic                       setupDone,
    output logic [SETUP_BITS-1:0]      setupData
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic sclkS;
    logic sdiS;
    logic senS;
    logic modeS;

    sscl_sync #(.RESET_VAL(SYNC_RESET)) uSyncClk (
        .clk     (clk),
        .rst     (rst),
        .pinIn   (serialClk),
        .syncOut (sclkS)
    );
    sscl_sync #(.RESET_VAL(SYNC_RESET)) uSyncDat (
        .clk     (clk),
        .rst     (rst),
        .pinIn   (serialIn),
        .syncOut (sdiS)
    );
    sscl_sync #(.RESET_VAL(SYNC_RESET_HI)) uSyncEn (
        .clk     (clk),
        .rst     (rst),
        .pinIn   (chain_enable_in_n),
        .syncOut (senS)
    );
    // the strap is a pin too; it is held steady through reset, so the
    // extra latency costs nothing
    sscl_sync #(.RESET_VAL(SYNC_RESET)) uSyncMode (
        .clk     (clk),
        .rst     (rst),
        .pinIn   (serialModeSel),
        .syncOut (modeS)
    );

    // ------------------------------------------------------------
    // mode strap and edge detect
    // ------------------------------------------------------------
    // strap caught once the synchroniser holds a real pin sample; taking it
    // earlier would latch the flops' reset value instead of the pin
    logic [1:0]  settle_reg;
    logic [1:0]  settle_next;
    logic        modeSeen_reg;
    logic        modeSeen_next;
    logic        serialMode_reg;
    logic        serialMode_next;
    logic        sclkPrev_reg;
    logic        sclkPrev_next;
    logic        sclkRise;

    always_comb begin
        // mirrors the synchroniser stages: bit 1 set once stage two is valid
        settle_next     = {settle_reg[0], 1'b1};
        modeSeen_next   = settle_reg[1];
        serialMode_next = modeSeen_reg ? serialMode_reg : modeS;
        sclkPrev_next   = sclkS;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settle_reg     <= SYNC_RESET;
            modeSeen_reg   <= 1'b0;
            serialMode_reg <= 1'b0;
            sclkPrev_reg   <= 1'b0;
        end else begin
            settle_reg     <= settle_next;
            modeSeen_reg   <= modeSeen_next;
            serialMode_reg <= serialMode_next;
            sclkPrev_reg   <= sclkPrev_next;
        end
    end

    assign sclkRise = sclkS & ~sclkPrev_reg;

    // ------------------------------------------------------------
    // loader state machine and shift register
    // ------------------------------------------------------------
    sscl_state_t           state_reg;
    sscl_state_t           state_next;
    logic [CNT_W-1:0]      cnt_reg;
    logic [CNT_W-1:0]      cnt_next;
    logic [SETUP_BITS-1:0] shift_reg;
    logic [SETUP_BITS-1:0] shift_next;
    logic                  take;

    // data sampled with the same latency as the clock edge
    assign take = sclkRise & ~senS;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        case (state_reg)
            SSCL_IDLE: begin
                if (modeSeen_reg) begin
                    // default programming completes at once
                    state_next = serialMode_reg ? SSCL_LOADING : SSCL_DONE;
                end
            end
            SSCL_LOADING: begin
                if (take) begin
                    shift_next = {shift_reg[SETUP_BITS-2:0], sdiS};
                    cnt_next   = cnt_reg + 7'h01;
                    if (cnt_reg == SETUP_COUNT - 7'h01) begin
                        state_next = SSCL_DONE;
                    end
                end
            end
            SSCL_DONE: begin
                state_next = SSCL_DONE;
            end
            default: begin
                state_next = SSCL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= SSCL_IDLE;
            cnt_reg   <= CNT_RESET;
            shift_reg <= SETUP_RESET;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
        end
    end

    // ------------------------------------------------------------
    // chain outputs
    // ------------------------------------------------------------
    logic done;
    logic senOut_reg;
    logic senOut_next;
    logic so_reg;
    logic so_next;

    assign done = (state_reg == SSCL_DONE);

    always_comb begin
        // high until done, then follows input
        senOut_next = done ? senS : 1'b1;
        // pass-through only once done and enable out low
        so_next     = (done && !senOut_reg) ? sdiS : 1'b0;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            senOut_reg <= 1'b1;
            so_reg     <= 1'b0;
        end else begin
            senOut_reg <= senOut_next;
            so_reg     <= so_next;
        end
    end

    assign chain_enable_out_n = senOut_reg;
    assign serialOut          = so_reg;
    assign setupDone          = done;
    assign setupData          = shift_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_no_load_default: assert property (@(posedge clk) disable iff (rst)
        (modeSeen_reg && !serialMode_reg) |-> ($stable(shift_reg)))
        else $error("setup storage changed in default mode");

    a_shift_on_edge: assert property (@(posedge clk) disable iff (rst)
        (state_reg == SSCL_LOADING && take) |=> (shift_reg[0] == $past(sdiS)))
        else $error("serial bit not captured");

    a_shift_advance: assert property (@(posedge clk) disable iff (rst)
        (state_reg == SSCL_LOADING && take) |=>
        (shift_reg[SETUP_BITS-1:1] == $past(shift_reg[SETUP_BITS-2:0])))
        else $error("shift register did not advance");

    a_hold_idle: assert property (@(posedge clk) disable iff (rst)
        (state_reg == SSCL_LOADING && !take) |=> $stable(shift_reg))
        else $error("shift without qualifying edge");

    a_enout_high: assert property (@(posedge clk) disable iff (rst)
        (!done && !$past(done)) |-> chain_enable_out_n)
        else $error("chain enable out low before done");

    a_enout_follow: assert property (@(posedge clk) disable iff (rst)
        done |=> (chain_enable_out_n == $past(senS)))
        else $error("chain enable out does not follow input");

    a_enout_done: assert property (@(posedge clk) disable iff (rst)
        $fell(chain_enable_out_n) |-> $past(done))
        else $error("chain enable out fell without completion");

    a_pass_through: assert property (@(posedge clk) disable iff (rst)
        (done && !chain_enable_out_n) |=> (serialOut == $past(sdiS)))
        else $error("serial data not passed through");

    a_so_quiet: assert property (@(posedge clk) disable iff (rst)
        !done |=> !serialOut)
        else $error("serial out active before loaded");
endmodule : sscl_loader

// ==== common/sscl_pkg.sv ====
// serial setup chain loader: shared constants
// assumes a 10 MHz system clock; no software-visible registers
package sscl_pkg;
    // ------------------------------------------------------------
    // setup storage geometry
    // ------------------------------------------------------------
    localparam int          SETUP_BITS    = 64;
    localparam int          CNT_W         = 7;
    localparam logic [6:0]  SETUP_COUNT   = 7'h40;
    localparam logic [6:0]  CNT_RESET     = 7'h00;
    localparam logic [63:0] SETUP_RESET   = 64'h0000000000000000;
    // ------------------------------------------------------------
    // synchroniser
    // ------------------------------------------------------------
    localparam int          SYNC_STAGES   = 2;
    localparam logic [1:0]  SYNC_RESET    = 2'h0;
    localparam logic [1:0]  SYNC_RESET_HI = 2'h3;
    // ------------------------------------------------------------
    // loader states (gray along the serial load path; the default-mode step from idle to done changes both bits)
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SSCL_IDLE    = 2'h0,
        SSCL_LOADING = 2'h1,
        SSCL_DONE    = 2'h3
    } sscl_state_t;
endpackage : sscl_pkg

// ==== rtl/sscl_sync.sv ====
// two-flop synchroniser for one pin input
// assumes input is asynchronous to clk
`timescale 1ns/100ps
module sscl_sync
    import sscl_pkg::*;
#(
    parameter logic [1:0] RESET_VAL = 2'h0
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pinIn,
    output logic      syncOut
);
    logic [1:0] stage_reg;
    logic [1:0] stage_next;

    always_comb begin
        stage_next = {stage_reg[0], pinIn};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage_reg <= RESET_VAL;
        end else begin
            stage_reg <= stage_next;
        end
    end

    // only the second stage is visible
    assign syncOut = stage_reg[1];
endmodule : sscl_sync

// ==== testbench/sscl_ctrl_model.sv ====
// setup controller model: serial clock, serial data, first chain enable
// assumes the bench calls its tasks; serial clock rests low between bits
`timescale 1ns/100ps
module sscl_ctrl_model (
    input  wire logic clk,
    output logic      serialClk,
    output logic      serialIn,
    output logic      enInN
);
    initial begin
        serialClk = 1'b0;
        serialIn  = 1'b0;
        enInN     = 1'b1;
    end
    // ----------------------------------------
    // one bit per 800 ns: clock high 4 cycles, low 4 cycles, data set 3 ahead
    // ----------------------------------------
    task automatic sendBit(input logic b);
        // the entry wait is the first low cycle of back-to-back bits
        @(posedge clk) serialIn <= b;
        repeat (3) @(posedge clk);
        serialClk <= 1'b1;
        repeat (4) @(posedge clk);
        serialClk <= 1'b0;
    endtask : sendBit
    task automatic setEnable(input logic v);
        @(posedge clk) enInN <= v;
    endtask : setEnable
endmodule : sscl_ctrl_model

// ==== testbench/serial_setup_chain_loader_bench.sv ====
// bench: default and serial loading, checked against a shift model
// assumes 10 MHz clk; serial output is left open as in a last device
`timescale 1ns/100ps
module serial_setup_chain_loader_bench;
    import sscl_pkg::*;
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  modeSel = 1'b0;
    logic                  sClk;
    logic                  sIn;
    logic                  enInN;
    logic                  enOutN;
    logic                  sOut;
    logic                  done;
    logic [SETUP_BITS-1:0] data;
    logic [63:0]           expData;
    logic                  b;
    bit                    sentQ[$];
    int                    mismatches = 0;
    int                    samples_checked = 0;
    int                    cycles = 0;
    always #50 clk = ~clk;
    sscl_ctrl_model ctrl_u (.clk(clk), .serialClk(sClk), .serialIn(sIn), .enInN(enInN));
    sscl_loader dut_u (
        .clk(clk), .rst(rst), .serialModeSel(modeSel), .serialClk(sClk), .serialIn(sIn),
        .chain_enable_in_n(enInN), .chain_enable_out_n(enOutN), .serialOut(sOut),
        .setupDone(done), .setupData(data)
    );
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    // mid-run resets reuse this, so the strap is retaken each time
    task automatic doReset(input logic m);
        @(posedge clk) rst <= 1'b1;
        modeSel <= m;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // strap passes two sync flops, is caught, then the state moves
        repeat (6) @(posedge clk);
        expData = 64'h0;
        sentQ.delete();
    endtask : doReset
    always @(posedge clk) begin
        cycles++;
        // tests need about 620 cycles; a few times that means a hang
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(1355));
        doReset(1'b0);
        check(done, 1);
        check(enOutN, 1);
        ctrl_u.setEnable(1'b0);
        repeat (2) ctrl_u.sendBit($urandom);
        check(enOutN, 0);
        check(data, 0);
        check(sOut, sIn);
        ctrl_u.setEnable(1'b1);
        repeat (6) @(posedge clk);
        check(enOutN, 1);
        $display("test default mode done");
        doReset(1'b1);
        repeat (2) ctrl_u.sendBit($urandom);
        check(data, 0);
        ctrl_u.setEnable(1'b0);
        for (int i = 0; i < 64; i++) begin
            b = 1'($urandom);
            ctrl_u.sendBit(b);
            sentQ.push_back(b);
            expData = 64'h0;
            foreach (sentQ[k]) expData = {expData[62:0], sentQ[k]};
            check(data, expData);
            if (i < 63) check({done, enOutN}, 2'h1);
        end
        repeat (4) @(posedge clk);
        check({done, enOutN}, 2'h2);
        for (int i = 0; i < 3; i++) begin
            ctrl_u.sendBit(i[0]);
            check(sOut, i[0]);
            check(data, expData);
        end
        ctrl_u.setEnable(1'b1);
        repeat (6) @(posedge clk);
        check(enOutN, 1);
        $display("test serial load done");
        print_verdict();
    end
endmodule : serial_setup_chain_loader_bench
